// ===== core/bdc_seq.sv
/*
  Built-in drive check sequencer: AXI4-Lite register slave, readiness
  check, three-segment test run, 20-deep results log, abort handling.
  Assumes a segment engine that runs one segment per go pulse and an
  external store that saves the log on each nv_store pulse.
*/

module bdc_seq #(
  parameter longint SHORT_LIMIT = bdc_pkg::SHORT_LIMIT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [bdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic motor_spin_ok,
  input wire logic motor_locked,
  input wire logic servo_locked,
  input wire logic tables_ok,
  input wire logic bus_reset,
  input wire logic bus_dev_reset,
  output logic seg_go,
  output logic [1:0] seg_sel,
  output logic seg_full,
  output logic seg_halt,
  input wire logic seg_done,
  input wire logic seg_fault,
  input wire logic seg_retries_out,
  input wire bdc_pkg::bdc_fail_t seg_fail,
  output logic nv_store,
  output bdc_pkg::bdc_entry_t nv_entry,
  output logic irq
);
  import bdc_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} bdc_state_t;

  // Mapped-address check, shared by read and write paths
  function automatic logic bdc_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CMD) || (a == REG_STATUS) || (a == REG_IRQ_STAT) ||
           (a == REG_IRQ_MASK) || (a == REG_EXT_DUR) || (a == REG_LOG_SEL) ||
           (a == REG_LOG_A) || (a == REG_LOG_B) || (a == REG_LOG_LBA);
  endfunction : bdc_mapped

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bdc_state_t state_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic aw_hold_r;
  logic [31:0] w_data_r;
  logic w_strb0_r;
  logic w_hold_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [4:0] log_sel_r;
  logic [4:0] log_cnt_r;
  logic [2:0] last_code_r;
  logic [1:0] seg_idx_r;
  logic seg_issued_r;
  logic [31:0] timer_r;
  logic short_r;
  logic ready_q_r;
  logic seg_go_r;
  logic seg_halt_r;
  logic nv_store_r;
  bdc_entry_t log_r [LOG_DEPTH];

  // ----------------------------------------------------------------
  // Readiness and not-ready sense
  // ----------------------------------------------------------------
  wire logic nr_motor = !motor_spin_ok || !motor_locked;
  wire logic nr_servo = !servo_locked;
  wire logic nr_tables = !tables_ok;
  wire logic [3:0] nr_cause = {nr_tables, nr_servo, !motor_locked, !motor_spin_ok};
  wire logic ready = !nr_motor && !nr_servo && !nr_tables;
  // Table faults report 04/03, mechanical faults 04/00
  wire logic [7:0] nr_ascq = nr_tables ? NR_ASCQ_TABLES : NR_ASCQ_CAUSE;
  wire logic [3:0] tur_key = ready ? 4'h0 : NR_KEY;
  wire logic [7:0] tur_asc = ready ? 8'h00 : NR_ASC;
  wire logic [7:0] tur_ascq = ready ? 8'h00 : nr_ascq;

  // ----------------------------------------------------------------
  // AXI write path
  // ----------------------------------------------------------------
  wire logic aw_take = ce && s_axi_awvalid && s_axi_awready;
  wire logic w_take = ce && s_axi_wvalid && s_axi_wready;
  wire logic wr_go = ce && aw_hold_r && w_hold_r && !bvalid_r;
  wire logic wr_ok = wr_go && bdc_mapped(aw_addr_r) && w_strb0_r;
  wire logic wr_cmd = wr_ok && (aw_addr_r == REG_CMD);
  wire logic wr_mask = wr_ok && (aw_addr_r == REG_IRQ_MASK);
  wire logic wr_sel = wr_ok && (aw_addr_r == REG_LOG_SEL);
  wire logic [2:0] cmd_code = w_data_r[CODE_MSB:CODE_LSB];

  // Each write channel waits until its own word has been used
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r <= 1'b0;
      w_data_r <= '0;
      w_strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= bdc_mapped(aw_addr_r) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode and test sequencing
  // ----------------------------------------------------------------
  wire logic idle = (state_r == ST_IDLE);
  wire logic run = (state_r == ST_RUN);
  wire logic is_test = (cmd_code == CODE_SHORT) || (cmd_code == CODE_EXT);
  wire logic start = wr_cmd && idle && is_test && ready;
  wire logic refused = wr_cmd && !start && !(run && cmd_code == CODE_ABORT);
  wire logic abort_app = run && wr_cmd && (cmd_code == CODE_ABORT);
  wire logic abort_rst = run && (bus_reset || bus_dev_reset);
  wire logic time_up = run && short_r && (timer_r >= 32'(SHORT_LIMIT - 1));
  // Recovered errors never end a test
  wire logic hard_err = seg_done && seg_fault && seg_retries_out;
  wire logic seg_end = run && seg_issued_r && seg_done && !abort_app && !abort_rst;
  wire logic fail_end = seg_end && hard_err;
  wire logic pass_end = (seg_end && !hard_err && seg_idx_r == SEG_SCAN) ||
                        (time_up && !seg_end && !abort_app && !abort_rst);
  wire logic finish = abort_app || abort_rst || fail_end || pass_end;

  // Outcome chosen by priority: app abort, reset abort, fault, pass
  wire logic [3:0] res_nxt = abort_app ? RES_ABORT_APP :
                             abort_rst ? RES_RESET :
                             fail_end ? 4'(RES_FAIL_BASE + 4'(seg_idx_r)) :
                             RES_PASS;

  assign seg_go = seg_go_r;
  assign seg_sel = seg_idx_r;
  assign seg_full = !short_r;
  assign seg_halt = seg_halt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      seg_idx_r <= SEG_ELEC;
      seg_issued_r <= 1'b0;
      seg_go_r <= 1'b0;
      seg_halt_r <= 1'b0;
      short_r <= 1'b0;
      timer_r <= '0;
      last_code_r <= '0;
    end else if (ce) begin
      seg_go_r <= 1'b0;
      seg_halt_r <= 1'b0;
      if (start) begin
        state_r <= ST_RUN;
        seg_idx_r <= SEG_ELEC;
        seg_issued_r <= 1'b0;
        short_r <= (cmd_code == CODE_SHORT);
        timer_r <= '0;
        last_code_r <= cmd_code;
      end else if (finish) begin
        state_r <= ST_IDLE;
        seg_halt_r <= !seg_end;
      end else if (run) begin
        timer_r <= timer_r + 32'h1;
        if (!seg_issued_r) begin
          seg_go_r <= 1'b1;
          seg_issued_r <= 1'b1;
        end else if (seg_end) begin
          seg_idx_r <= seg_idx_r + 2'h1;
          seg_issued_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Results log: entry 0 is the newest block
  // ----------------------------------------------------------------
  bdc_entry_t new_entry;
  assign new_entry = '{code: cmd_code, result: RES_RUNNING, fail: '0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_r[0] <= '0;
    end else if (ce) begin
      if (start) begin
        log_r[0] <= new_entry;
      end else if (finish) begin
        log_r[0].result <= res_nxt;
        if (fail_end) begin
          log_r[0].fail <= seg_fail;
        end
      end
    end
  end

  // Older blocks slide back; the last one falls off the end
  for (genvar i = 1; i < LOG_DEPTH; i++) begin : g_log
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        log_r[i] <= '0;
      end else if (ce && start) begin
        log_r[i] <= log_r[i-1];
      end
    end
  end

  // Count saturates at the log depth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_cnt_r <= '0;
      nv_store_r <= 1'b0;
    end else if (ce) begin
      nv_store_r <= start || finish;
      if (start && log_cnt_r != 5'(LOG_DEPTH)) begin
        log_cnt_r <= log_cnt_r + 5'h1;
      end
    end
  end

  // Store pulse rises on the same edge that changes the front block
  assign nv_store = nv_store_r;
  assign nv_entry = log_r[0];

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  wire logic rd_take = ce && s_axi_arvalid && s_axi_arready;
  wire logic rd_irq = rd_take && (s_axi_araddr == REG_IRQ_STAT);
  wire logic nr_rise = ready_q_r && !ready;
  wire logic [IRQ_W-1:0] irq_set = {nr_rise, refused, abort_app || abort_rst,
                                    fail_end, pass_end};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      ready_q_r <= 1'b0;
    end else if (ce) begin
      ready_q_r <= ready;
      // New events win over the clear by read
      irq_stat_r <= (rd_irq ? '0 : irq_stat_r) | irq_set;
      if (wr_mask) begin
        irq_mask_r <= w_data_r[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Log view select and AXI read path
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_sel_r <= '0;
    end else if (ce && wr_sel) begin
      log_sel_r <= (w_data_r[4:0] > LOG_LAST) ? LOG_LAST : w_data_r[4:0];
    end
  end

  bdc_entry_t view;
  assign view = log_r[log_sel_r];

  wire logic [31:0] rd_status = {4'h0, tur_key, tur_ascq, tur_asc, nr_cause, ready,
                                 seg_idx_r, run};
  wire logic [31:0] rd_log_a = {view.fail.ascq, view.fail.asc, 4'h0, view.fail.key,
                                view.result, 1'b0, view.code};
  wire logic [31:0] rd_log_b = {11'h0, log_cnt_r, 7'h0, view.fail.lba_vld,
                                view.fail.fru};
  wire logic [31:0] rd_mux =
      (s_axi_araddr == REG_CMD) ? {24'h0, last_code_r, 5'h0} :
      (s_axi_araddr == REG_STATUS) ? rd_status :
      (s_axi_araddr == REG_IRQ_STAT) ? {27'h0, irq_stat_r} :
      (s_axi_araddr == REG_IRQ_MASK) ? {27'h0, irq_mask_r} :
      (s_axi_araddr == REG_EXT_DUR) ? {16'h0, EXT_DUR_MIN} :
      (s_axi_araddr == REG_LOG_SEL) ? {27'h0, log_sel_r} :
      (s_axi_araddr == REG_LOG_A) ? rd_log_a :
      (s_axi_araddr == REG_LOG_B) ? rd_log_b :
      (s_axi_araddr == REG_LOG_LBA) ? view.fail.lba : 32'h0;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= bdc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule : bdc_seq

// ===== shared/bdc_pkg.sv
/*
  Shared constants and types of the built-in drive check sequencer:
  register map, field layouts, test codes, result codes and timing.
  Assumes a 25 MHz register clock and a 32-bit AXI4-Lite bus.
*/
package bdc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_EXT_DUR = 8'h10;
  localparam logic [7:0] REG_LOG_SEL = 8'h14;
  localparam logic [7:0] REG_LOG_A = 8'h18;
  localparam logic [7:0] REG_LOG_B = 8'h1c;
  localparam logic [7:0] REG_LOG_LBA = 8'h20;

  // ----------------------------------------------------------------
  // Command field and codes
  // ----------------------------------------------------------------
  localparam int CODE_LSB = 5;
  localparam int CODE_MSB = 7;
  localparam logic [2:0] CODE_SHORT = 3'h1;
  localparam logic [2:0] CODE_EXT = 3'h2;
  localparam logic [2:0] CODE_ABORT = 3'h4;

  // ----------------------------------------------------------------
  // Results log and outcome values
  // ----------------------------------------------------------------
  localparam int LOG_DEPTH = 20;
  localparam logic [4:0] LOG_LAST = 5'h13;
  localparam logic [3:0] RES_PASS = 4'h0;
  localparam logic [3:0] RES_ABORT_APP = 4'h1;
  localparam logic [3:0] RES_RESET = 4'h2;
  localparam logic [3:0] RES_FAIL_BASE = 4'h5;
  localparam logic [3:0] RES_RUNNING = 4'hf;

  // Segments run in this order
  localparam logic [1:0] SEG_ELEC = 2'h0;
  localparam logic [1:0] SEG_SERVO = 2'h1;
  localparam logic [1:0] SEG_SCAN = 2'h2;

  // Not-ready sense: key 02, ASC 04, ASCQ 00 or 03
  localparam logic [3:0] NR_KEY = 4'h2;
  localparam logic [7:0] NR_ASC = 8'h04;
  localparam logic [7:0] NR_ASCQ_CAUSE = 8'h00;
  localparam logic [7:0] NR_ASCQ_TABLES = 8'h03;

  // Interrupt bits
  localparam int IRQ_W = 5;
  localparam int IRQ_PASS = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_REFUSED = 3;
  localparam int IRQ_NOT_READY = 4;

  // Extended test duration in minutes, reported to the host
  localparam logic [15:0] EXT_DUR_MIN = 16'h003c;

  // Short test time limit
  localparam longint CLK_HZ = 25_000_000;
  localparam longint SHORT_LIMIT_S = 120;
  localparam longint SHORT_LIMIT_CYC = SHORT_LIMIT_S * CLK_HZ;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Failure description from the segment engine
  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] fru;
    logic lba_vld;
    logic [31:0] lba;
  } bdc_fail_t;

  // One result block of the log
  typedef struct packed {
    logic [2:0] code;
    logic [3:0] result;
    bdc_fail_t fail;
  } bdc_entry_t;

endpackage : bdc_pkg

// ===== verif/bdc_seg_model.sv
/*
  Segment engine model: answers each go pulse after a random delay,
  with a fault on one chosen segment. Assumes one-cycle go and halt.
*/
module bdc_seg_model
  import bdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic seg_go,
  input wire logic [1:0] seg_sel,
  input wire logic seg_halt,
  input wire logic hold,
  input wire logic [1:0] bad_seg,
  input wire logic recov,
  input wire bdc_pkg::bdc_fail_t fail_in,
  output logic seg_done,
  output logic seg_fault,
  output logic seg_retries_out,
  output bdc_pkg::bdc_fail_t seg_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  logic busy_r = 1'b0;
  logic hit;
  logic bad;
  assign hit = busy_r && !hold && cnt_r == 4'h0;
  assign bad = hit && seg_sel == bad_seg;
  // ----------------------------------------------------------------
  // Segment run; hold keeps it busy until halted
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    seg_done <= hit;
    seg_fault <= bad;
    seg_retries_out <= bad && !recov;
    seg_fail <= hit ? fail_in : ~fail_in; // Garbage outside done
    if (!aresetn || seg_halt || hit) begin
      busy_r <= 1'b0;
    end else if (seg_go) begin
      busy_r <= 1'b1;
      cnt_r <= 4'($urandom_range(9, 2));
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : bdc_seg_model

// ===== verif/bdc_seq_asserts.sv
/*
  Checker of the sequencer's segment link and log stores.
  Sees only the sequencer's ports; bound at the foot of this file.
*/
module bdc_seq_asserts
  import bdc_pkg::*;
#(
  parameter longint SHORT_LIMIT = 200
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_reset,
  input wire logic bus_dev_reset,
  input wire logic seg_go,
  input wire logic [1:0] seg_sel,
  input wire logic seg_full,
  input wire logic seg_halt,
  input wire logic seg_done,
  input wire logic seg_fault,
  input wire logic seg_retries_out,
  input wire logic nv_store,
  input wire bdc_pkg::bdc_entry_t nv_entry
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic run;
  logic quiet;
  logic ok_done;
  logic [31:0] cnt_r;
  // Test under way while the front block reads in progress
  assign run = nv_entry.result == RES_RUNNING;
  assign quiet = !bus_reset && !bus_dev_reset;
  assign ok_done = seg_done && run && quiet && !(seg_fault && seg_retries_out);
  // Cycles spent running, for the time limit
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_step;
    ok_done && seg_sel != SEG_SCAN ##1 quiet;
  endsequence
  sequence s_stop(logic [3:0] r);
    (seg_halt && nv_store && nv_entry.result == r) ##1 (!seg_halt && !nv_store);
  endsequence
  AST_START: assert property (nv_store && run |=> seg_go && seg_sel == SEG_ELEC
    && seg_full == (nv_entry.code == CODE_EXT)) else $error("bad test start");
  AST_NEXT: assert property (s_step |-> ##1 seg_go
    && seg_sel == $past(seg_sel, 2) + 2'h1) else $error("segment order broken");
  AST_PASS: assert property (ok_done && seg_sel == SEG_SCAN |-> ##[1:2]
    nv_store && nv_entry.result == RES_PASS) else $error("pass not stored");
  AST_FAIL: assert property (seg_done && run && quiet && seg_fault && seg_retries_out
    |-> ##[1:2] nv_store && nv_entry.result == RES_FAIL_BASE + 4'(seg_sel))
    else $error("failure not stored");
  AST_RESET_ABORT: assert property (run && !quiet |=> s_stop(RES_RESET))
    else $error("reset abort wrong");
  AST_SHORT: assert property (nv_entry.code == CODE_SHORT |->
    cnt_r <= 32'(SHORT_LIMIT) + 32'h4) else $error("short test too long");
  AST_GO_PULSE: assert property (seg_go |=> !seg_go) else $error("go not a pulse");
  AST_HALT: assert property (seg_halt |=> !seg_halt && !seg_go)
    else $error("halt not a pulse");
endmodule : bdc_seq_asserts

bind bdc_seq bdc_seq_asserts #(.SHORT_LIMIT(SHORT_LIMIT)) u_chk (.aclk, .aresetn, .bus_reset,
  .bus_dev_reset, .seg_go, .seg_sel, .seg_full, .seg_halt, .seg_done, .seg_fault,
  .seg_retries_out, .nv_store, .nv_entry);

// ===== verif/drive_self_test_sequencer_tb.sv
/*
  Testbench of the sequencer: AXI4-Lite master, segment model, queued
  expectations. Assumes the checker is bound in separately.
*/
module drive_self_test_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bdc_pkg::*;
  localparam longint LIM = 200;
  typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} bdc_rd_t;
  typedef struct {logic [2:0] c; logic [3:0] r;} bdc_nv_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, bus_reset = 0, bus_dev_reset = 0, hold = 0, recov = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, seg_sel, bad_seg = 2'h3;
  logic [3:0] rdy = 4'hf;
  logic seg_go, seg_full, seg_halt, seg_done, seg_fault, seg_retries_out, nv_store, irq;
  bdc_fail_t fail_in = '0, seg_fail;
  bdc_entry_t nv_entry;
  int n_errors = 0, num_checks = 0;
  bdc_rd_t rq[$];
  bdc_nv_t nq[$];
  always #20 aclk = ~aclk;
  bdc_seq #(.SHORT_LIMIT(LIM)) uut (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motor_spin_ok(rdy[0]), .motor_locked(rdy[1]),
    .servo_locked(rdy[2]), .tables_ok(rdy[3]), .bus_reset, .bus_dev_reset, .seg_go, .seg_sel,
    .seg_full, .seg_halt, .seg_done, .seg_fault, .seg_retries_out, .seg_fail, .nv_store,
    .nv_entry, .irq);
  bdc_seg_model u_model (.aclk, .aresetn, .seg_go, .seg_sel, .seg_halt, .hold, .bad_seg,
    .recov, .fail_in, .seg_done, .seg_fault, .seg_retries_out, .seg_fail);
  // ----------------------------------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic tmo();
    chk(32'h0, 32'h1); // Wait ran out
    summarize();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (s_axi_bvalid !== 1'b1) tmo();
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
    int n;
    rq.push_back('{e & m, m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (s_axi_rvalid !== 1'b1) tmo();
    s_axi_rready <= 1'b0;
  endtask : rd
  // Start a test, noting both log stores it must make
  task automatic start(input logic [2:0] c, input logic [3:0] r);
    nq.push_back('{c, RES_RUNNING});
    nq.push_back('{c, r});
    wr(REG_CMD, {24'h0, c, 5'h0}, RESP_OKAY);
  endtask : start
  task automatic waitq(input int left);
    int n;
    for (n = 0; n < LIM + 300 && nq.size() > left; n++) @(posedge aclk);
    if (nq.size() > left) tmo();
  endtask : waitq
  // Watcher: oldest note against each answer or store
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0) begin
      chk(s_axi_rdata & rq[0].m, rq[0].e);
      chk(32'(s_axi_rresp), 32'(rq[0].r));
      void'(rq.pop_front());
    end
    if (nv_store === 1'b1) begin
      chk(32'(nv_entry.code), (nq.size() > 0) ? 32'(nq[0].c) : 32'hff);
      chk(32'(nv_entry.result), (nq.size() > 0) ? 32'(nq[0].r) : 32'hff);
      void'(nq.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [3:0] res;
    logic [2:0] c;
    static logic [1:0] bads [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    void'($urandom(32'h0d24ccf2));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_STATUS, 32'h8, '1, RESP_OKAY);
    rd(REG_EXT_DUR, 32'(EXT_DUR_MIN), '1, RESP_OKAY);
    rd(8'h40, 0, 0, RESP_DECERR);
    wr(8'h40, 0, RESP_DECERR);
    wr(REG_IRQ_MASK, 32'h1f, RESP_OKAY);
    $display("Test idle done");
    // Each not-ready cause, then a refused start
    for (i = 0; i < 4; i++) begin
      rdy <= ~(4'h1 << i);
      rd(REG_STATUS, {4'h0, NR_KEY, (i == 3) ? NR_ASCQ_TABLES : NR_ASCQ_CAUSE, NR_ASC,
        4'(1 << i), 4'h0}, 32'h0ffffff9, RESP_OKAY);
    end
    wr(REG_CMD, {24'h0, CODE_SHORT, 5'h0}, RESP_OKAY);
    rd(REG_IRQ_STAT, 32'h8, 32'h8, RESP_OKAY);
    rd(REG_LOG_B, 0, 32'h001f0000, RESP_OKAY);
    chk(32'(irq), 0);
    rdy <= 4'hf;
    wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
    $display("Test not ready done");
    // Recovered fault, pass, failures; pass raises the interrupt, fail is masked
    for (i = 0; i < 4; i++) begin
      bad_seg <= bads[i];
      recov <= (i == 0);
      fail_in <= 61'({$urandom(), $urandom()});
      res = (i < 2) ? RES_PASS : RES_FAIL_BASE + 4'(bads[i]);
      c = i[0] ? CODE_EXT : CODE_SHORT;
      start(c, res);
      waitq(0);
      wr(REG_LOG_SEL, 0, RESP_OKAY);
      rd(REG_LOG_A, {fail_in.ascq, fail_in.asc, 4'h0, fail_in.key, res, 1'b0, c},
        (i < 2) ? 32'hf7 : 32'hffff0ff7, RESP_OKAY);
      rd(REG_LOG_LBA, (i < 2) ? 32'h0 : fail_in.lba, '1, RESP_OKAY);
      rd(REG_LOG_B, (i < 2) ? 32'h0 : {23'h0, fail_in.lba_vld, fail_in.fru}, 32'h1ff,
        RESP_OKAY);
      chk(32'(irq), 32'(i < 2));
      rd(REG_IRQ_STAT, (i < 2) ? 32'h1 : 32'h2, 32'h3, RESP_OKAY);
    end
    $display("Test runs done");
    // Abort by code, bus reset, device reset, then time limit
    hold <= 1'b1;
    for (i = 0; i < 3; i++) begin
      start(CODE_EXT, (i == 0) ? RES_ABORT_APP : RES_RESET);
      waitq(1);
      if (i == 0) begin
        wr(REG_CMD, {24'h0, CODE_ABORT, 5'h0}, RESP_OKAY);
      end else begin
        {bus_dev_reset, bus_reset} <= 2'(i);
        @(posedge aclk);
        {bus_dev_reset, bus_reset} <= 2'h0;
      end
      waitq(0);
    end
    start(CODE_SHORT, RES_PASS);
    waitq(0);
    hold <= 1'b0;
    bad_seg <= 2'h3;
    $display("Test aborts done");
    // Overfill the log; oldest must drop
    for (i = 0; i < 13; i++) begin
      start(CODE_SHORT, RES_PASS);
      waitq(0);
    end
    wr(REG_LOG_SEL, 32'h1f, RESP_OKAY);
    rd(REG_LOG_SEL, 32'(LOG_LAST), '1, RESP_OKAY);
    rd(REG_LOG_A, {29'h0, CODE_EXT}, 32'hf7, RESP_OKAY);
    rd(REG_LOG_B, 32'(LOG_DEPTH) << 16, 32'h001f0000, RESP_OKAY);
    rd(REG_CMD, {24'h0, CODE_SHORT, 5'h0}, '1, RESP_OKAY);
    $display("Test log depth done");
    summarize();
  end
endmodule : drive_self_test_sequencer_tb
